// File: rtl/uwb_lut_mem.sv
`timescale 1ns/1ps
module uwb_lut_mem (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic we,
  input wire logic [uwb_pkg::LUT_AW-1:0] waddr,
  input wire logic [31:0] wdata,
  input wire logic [uwb_pkg::LUT_AW-1:0] ra_addr,
  output logic [31:0] ra_data,
  input wire logic [uwb_pkg::LUT_AW-1:0] rb_addr,
  output logic [31:0] rb_data
);
  import uwb_pkg::*;

  logic [31:0] mem [LUT_DEPTH];

  // Entries clear at reset so every page starts disabled.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < LUT_DEPTH; i++) begin
        mem[i] <= REG_RST;
      end
    end else if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ra_data <= REG_RST;
      rb_data <= REG_RST;
    end else begin
      ra_data <= mem[ra_addr];
      rb_data <= mem[rb_addr];
    end
  end

endmodule : uwb_lut_mem

// File: rtl/uwb_regs.sv
// Functional notes
// R1: Window 1 bit 0 shows the space and bits 2:1 the address type, read-only, reset 0.
// R2: Bit 3 of both windows is a read-only prefetch flag that resets to 0.
// R3: A window 1 base bit in 31:6 is writable only where its setup bit is one; for IO the code makes bits 31:8 writable regardless.
// R4: Setup bit 31 at zero disables window 1 entirely.
// R5: Window 1 spans 4KB to 2GB for memory and 64B to 256B for IO.
// R6: Window 1 hits are translated by substituting the translated base.
// R7: Setup registers load from the serial loader port or software.
// R8: Window 2 address type always reads 00, a 32-bit decoder.
// R9: Window 2 base bits 31:14 define a memory-only range of 16KB to 2GB.
// R10: Window 2 is cut into 64 pages translated through a lookup table.
// R11: A lookup entry with bit 0 clear disables its page; entries sit at 100h-1FFh.
// R12: Window 2 writable base bits follow the configured page size.
// R13: A window hits only when enabled and the address lies inside it.
`timescale 1ns/1ps
module uwb_regs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [uwb_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [uwb_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire uwb_pkg::uwb_load_t load,
  input wire uwb_pkg::uwb_xreq_t xreq,
  output uwb_pkg::uwb_xrsp_t xrsp,
  output logic win1_enabled,
  output logic win2_enabled
);
  import uwb_pkg::*;

  // ************************************************************
  // Helper functions
  // ************************************************************
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // R5: size limits
  // Memory windows never go below 4KB, IO windows never above 256B.
  function automatic logic [31:0] win1_mask(input logic [31:0] setup);
    logic [31:0] m;
    m = {setup[31:WIN1_BASE_LSB], {WIN1_BASE_LSB{1'b0}}};
    if (setup[SPACE_BIT]) begin
      m[31:IO_MAX_LSB] = '1;
    end else begin
      m[MEM_MIN_LSB-1:0] = '0;
    end
    return m;
  endfunction : win1_mask

  function automatic logic [4:0] pcode(input logic [31:0] fwd);
    logic [4:0] c;
    c = fwd[PCODE_MSB:0];
    if (c > PCODE_MAX) begin
      c = PCODE_MAX;
    end
    return c;
  endfunction : pcode

  // R12: mask from page size
  // The window is 64 pages, so it starts at bit 14 plus the page code.
  function automatic logic [31:0] win2_mask(input logic [31:0] fwd);
    return 32'hffff_ffff << (WIN2_BASE_LSB + 32'(pcode(fwd)));
  endfunction : win2_mask

  function automatic logic [31:0] page_mask(input logic [31:0] fwd);
    return 32'hffff_ffff << (PAGE_MIN_LSB + 32'(pcode(fwd)));
  endfunction : page_mask

  function automatic logic is_mapped(input logic [11:0] a);
    return a[11:8] == LUT_PAGE ||
           a[11:2] == OFS_WIN1_BASE[11:2] ||
           a[11:2] == OFS_WIN2_BASE[11:2] ||
           a[11:2] == OFS_WIN1_XLAT[11:2] ||
           a[11:2] == OFS_WIN1_SETUP[11:2] ||
           a[11:2] == OFS_FWD_CTRL[11:2];
  endfunction : is_mapped

  // ************************************************************
  // Registers and bus state
  // ************************************************************
  logic [31:0] base1;
  logic [31:0] base2;
  logic [31:0] xlat1;
  logic [31:0] setup1;
  logic [31:0] fwd_ctrl;
  logic aw_held;
  logic w_held;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic rd_pend;
  logic [11:0] rd_addr;
  logic [31:0] lut_a;
  logic [31:0] lut_b;
  logic [31:0] mask1;
  logic [31:0] mask2;
  logic [31:0] pmask;
  logic do_wr;
  logic [31:0] win1_rd;
  logic [31:0] win2_rd;
  logic [31:0] next_rdata;
  logic s1_valid;
  logic s1_hit1;
  logic s1_hit2;
  logic [31:0] s1_addr;
  logic [31:0] s1_xaddr1;
  logic [31:0] s1_pmask;

  assign mask1 = win1_mask(setup1);
  assign mask2 = win2_mask(fwd_ctrl);
  assign pmask = page_mask(fwd_ctrl);
  assign do_wr = aw_held && w_held && !s_axi_bvalid;

  // R1: window 1 identity bits
  // R2: prefetch flags
  // R8: window 2 type fixed
  always_comb begin
    win1_rd = base1 & mask1;
    win1_rd[SPACE_BIT] = setup1[SPACE_BIT];
    win1_rd[TYPE_MSB:TYPE_LSB] = setup1[TYPE_MSB:TYPE_LSB];
    win1_rd[PREF_BIT] = setup1[PREF_BIT];
    win2_rd = base2 & mask2;
    win2_rd[TYPE_MSB:TYPE_LSB] = TYPE_32;
    win2_rd[PREF_BIT] = fwd_ctrl[PREF_BIT];
  end

  // ************************************************************
  // Write channel
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      wr_addr <= '0;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      wr_addr <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (do_wr) begin
      aw_held <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      wr_data <= REG_RST;
      wr_strb <= '0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      wr_data <= s_axi_wdata;
      wr_strb <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (do_wr) begin
      w_held <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= is_mapped(wr_addr) ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ************************************************************
  // Base registers
  // ************************************************************
  // R3: per-bit write enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      base1 <= REG_RST;
    end else if (do_wr && wr_addr[11:2] == OFS_WIN1_BASE[11:2]) begin
      base1 <= (base1 & ~mask1) |
               (merge(base1, wr_data, wr_strb) & mask1);
    end
  end

  // R9: memory-only window 2 base
  // R12: writable bits track page size
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      base2 <= REG_RST;
    end else if (do_wr && wr_addr[11:2] == OFS_WIN2_BASE[11:2]) begin
      base2 <= (base2 & ~mask2) |
               (merge(base2, wr_data, wr_strb) & mask2);
    end
  end

  // ************************************************************
  // Setup registers
  // ************************************************************
  // R7: loader wins over software
  // The serial loader is the boot-time owner, so it takes priority.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      setup1 <= REG_RST;
    end else if (load.valid && load.addr[11:2] == OFS_WIN1_SETUP[11:2]) begin
      setup1 <= load.data;
    end else if (do_wr && wr_addr[11:2] == OFS_WIN1_SETUP[11:2]) begin
      setup1 <= merge(setup1, wr_data, wr_strb);
    end
  end

  // R7: translated base load
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xlat1 <= REG_RST;
    end else if (load.valid && load.addr[11:2] == OFS_WIN1_XLAT[11:2]) begin
      xlat1 <= load.data;
    end else if (do_wr && wr_addr[11:2] == OFS_WIN1_XLAT[11:2]) begin
      xlat1 <= merge(xlat1, wr_data, wr_strb);
    end
  end

  // R7: page size control load
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fwd_ctrl <= REG_RST;
    end else if (load.valid && load.addr[11:2] == OFS_FWD_CTRL[11:2]) begin
      fwd_ctrl <= load.data;
    end else if (do_wr && wr_addr[11:2] == OFS_FWD_CTRL[11:2]) begin
      fwd_ctrl <= merge(fwd_ctrl, wr_data, wr_strb);
    end
  end

  // ************************************************************
  // Lookup table
  // ************************************************************
  // R11: entries at 100h-1FFh
  // Byte strobes are ignored here: entries always take a full word.
  uwb_lut_mem u_lut (
    .aclk(aclk),
    .aresetn(aresetn),
    .we(do_wr && wr_addr[11:8] == LUT_PAGE),
    .waddr(wr_addr[LUT_AW+1:2]),
    .wdata(wr_data),
    .ra_addr(s_axi_araddr[LUT_AW+1:2]),
    .ra_data(lut_a),
    .rb_addr(LUT_AW'((xreq.addr & ~mask2) >>
                     (PAGE_MIN_LSB + 32'(pcode(fwd_ctrl))))),
    .rb_data(lut_b)
  );

  // ************************************************************
  // Read channel
  // ************************************************************
  always_comb begin
    next_rdata = REG_RST;
    if (rd_addr[11:8] == LUT_PAGE) begin
      next_rdata = lut_a;
    end else begin
      case (rd_addr[11:2])
        OFS_WIN1_BASE[11:2]: next_rdata = win1_rd;
        OFS_WIN2_BASE[11:2]: next_rdata = win2_rd;
        OFS_WIN1_XLAT[11:2]: next_rdata = xlat1;
        OFS_WIN1_SETUP[11:2]: next_rdata = setup1;
        OFS_FWD_CTRL[11:2]: next_rdata = fwd_ctrl;
        default: next_rdata = REG_RST;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      rd_pend <= 1'b0;
      rd_addr <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      rd_pend <= 1'b1;
      rd_addr <= s_axi_araddr;
    end else if (rd_pend) begin
      rd_pend <= 1'b0;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= REG_RST;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_pend) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= is_mapped(rd_addr) ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ************************************************************
  // Window decode and translation
  // ************************************************************
  // R4: setup bit 31 enables window 1
  // R13: windows gated by enables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      win1_enabled <= 1'b0;
      win2_enabled <= 1'b0;
    end else begin
      win1_enabled <= setup1[EN_BIT];
      win2_enabled <= fwd_ctrl[EN_BIT];
    end
  end

  // R13: range compare
  // R6: direct substitution
  // The table read takes a cycle, so decode is split over two stages.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_valid <= 1'b0;
      s1_hit1 <= 1'b0;
      s1_hit2 <= 1'b0;
      s1_addr <= '0;
      s1_xaddr1 <= '0;
      s1_pmask <= '0;
    end else begin
      s1_valid <= xreq.valid;
      s1_hit1 <= xreq.valid && setup1[EN_BIT] &&
                 xreq.is_io == setup1[SPACE_BIT] &&
                 (xreq.addr & mask1) == (base1 & mask1);
      s1_hit2 <= xreq.valid && fwd_ctrl[EN_BIT] && !xreq.is_io &&
                 (xreq.addr & mask2) == (base2 & mask2);
      s1_addr <= xreq.addr;
      s1_xaddr1 <= (xlat1 & mask1) | (xreq.addr & ~mask1);
      s1_pmask <= pmask;
    end
  end

  // R10: page translation
  // R11: entry bit 0 gates page
  // Window 1 wins when both windows overlap.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xrsp <= '0;
    end else begin
      xrsp.valid <= s1_valid;
      xrsp.hit1 <= s1_hit1;
      xrsp.hit2 <= s1_hit2 && !s1_hit1 && lut_b[LUT_EN_BIT];
      if (s1_hit1) begin
        xrsp.addr <= s1_xaddr1;
      end else if (s1_hit2 && lut_b[LUT_EN_BIT]) begin
        xrsp.addr <= (lut_b & s1_pmask) | (s1_addr & ~s1_pmask);
      end else begin
        xrsp.addr <= s1_addr;
      end
    end
  end

endmodule : uwb_regs

// File: shared/uwb_pkg.sv
package uwb_pkg;

  // ************************************************************
  // Register map (byte addresses on the register bus)
  // ************************************************************
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFS_WIN1_BASE = 12'h058;
  localparam logic [11:0] OFS_WIN2_BASE = 12'h05c;
  localparam logic [11:0] OFS_WIN1_XLAT = 12'h0e8;
  localparam logic [11:0] OFS_WIN1_SETUP = 12'h0ec;
  localparam logic [11:0] OFS_FWD_CTRL = 12'h0f0;
  localparam logic [3:0] LUT_PAGE = 4'h1;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int unsigned SPACE_BIT = 0;
  localparam int unsigned TYPE_LSB = 1;
  localparam int unsigned TYPE_MSB = 2;
  localparam int unsigned PREF_BIT = 3;
  localparam int unsigned EN_BIT = 31;
  localparam int unsigned LUT_EN_BIT = 0;
  localparam int unsigned WIN1_BASE_LSB = 6;
  localparam int unsigned MEM_MIN_LSB = 12;
  localparam int unsigned IO_MAX_LSB = 8;
  localparam int unsigned WIN2_BASE_LSB = 14;
  localparam int unsigned PAGE_MIN_LSB = 8;
  localparam int unsigned PCODE_MSB = 4;
  localparam logic [4:0] PCODE_MAX = 5'h11;
  localparam int unsigned LUT_DEPTH = 64;
  localparam int unsigned LUT_AW = 6;

  // ************************************************************
  // Encodings and reset values
  // ************************************************************
  localparam logic [1:0] TYPE_32 = 2'h0;
  localparam logic [1:0] TYPE_64 = 2'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam logic [31:0] REG_RST = 32'h0000_0000;

  typedef struct packed {
    logic valid;
    logic [11:0] addr;
    logic [31:0] data;
  } uwb_load_t;

  typedef struct packed {
    logic valid;
    logic is_io;
    logic [31:0] addr;
  } uwb_xreq_t;

  typedef struct packed {
    logic valid;
    logic hit1;
    logic hit2;
    logic [31:0] addr;
  } uwb_xrsp_t;

endpackage : uwb_pkg

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import uwb_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0;
  logic [11:0] s_axi_araddr = 12'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  uwb_load_t load = '0;
  uwb_xreq_t xreq = '0;
  uwb_xrsp_t xrsp;
  logic win1_enabled, win2_enabled;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;

  uwb_regs DUT (.*);

  initial begin
    forever #20 aclk = ~aclk;
  end

  // The whole run needs well under a thousand cycles.
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      wrap_up();
    end
  end

  // ************************************************************
  // Access tasks
  // ************************************************************
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] r = RESP_OKAY);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, r}, {30'h0, s_axi_bresp});
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [1:0] r = RESP_OKAY);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rresp", {30'h0, r}, {30'h0, s_axi_rresp});
    chk("rdata", e, s_axi_rdata);
  endtask : rd

  // The loader pulse lasts one cycle; the enable copy lags one more.
  task automatic ld(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    load <= '{1'b1, a, d};
    @(posedge aclk);
    load.valid <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask : ld

  task automatic xq(input logic [31:0] a, input logic io,
                    input logic [1:0] h, input logic [31:0] e);
    int n;
    n = 0;
    @(posedge aclk);
    xreq <= '{1'b1, io, a};
    @(posedge aclk);
    xreq.valid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (xrsp.valid !== 1'b1 && n < 4);
    chk("xrsp valid", 32'h1, {31'h0, xrsp.valid});
    chk("hits", {30'h0, h}, {30'h0, xrsp.hit1, xrsp.hit2});
    chk("xaddr", e, xrsp.addr);
  endtask : xq

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_WIN1_BASE, REG_RST);
    rd(OFS_WIN2_BASE, REG_RST);
    rd(12'h004, 32'h0, RESP_DECERR);
    wr(12'h004, 32'hffff_ffff, RESP_DECERR);
    ld(OFS_WIN1_SETUP, 32'hffff_f008);
    chk("win1 en", 32'h1, {31'h0, win1_enabled});
    wr(OFS_WIN1_BASE, 32'hffff_ffff);
    rd(OFS_WIN1_BASE, 32'hffff_f008);
    wr(OFS_WIN1_SETUP, 32'hffff_0002);
    wr(OFS_WIN1_BASE, 32'h1234_5678);
    rd(OFS_WIN1_BASE, 32'h1234_0002);
    ld(OFS_WIN1_SETUP, 32'h8000_00c1);
    wr(OFS_WIN1_BASE, 32'hffff_ffff);
    rd(OFS_WIN1_BASE, 32'hffff_ffc1);
    xq(32'hffff_ffd5, 1'b1, 2'b10, 32'h0000_0015);
    ld(OFS_WIN1_SETUP, 32'hffff_f000);
    wr(OFS_WIN1_XLAT, 32'h9000_0000);
    wr(OFS_WIN1_BASE, 32'h4000_0000);
    xq(32'h4000_0abc, 1'b0, 2'b10, 32'h9000_0abc);
    xq(32'h4000_1000, 1'b0, 2'b00, 32'h4000_1000);
    xq(32'h4000_0abc, 1'b1, 2'b00, 32'h4000_0abc);
    ld(OFS_WIN1_SETUP, 32'h7fff_f000);
    chk("win1 en", 32'h0, {31'h0, win1_enabled});
    xq(32'h4000_0abc, 1'b0, 2'b00, 32'h4000_0abc);
    wr(OFS_FWD_CTRL, 32'h8000_0008);
    wr(OFS_WIN2_BASE, 32'hffff_ffff);
    // Bit 3 is both the prefetch flag and part of the page code.
    rd(OFS_WIN2_BASE, 32'hffc0_0008);
    wr(OFS_FWD_CTRL, 32'h8000_0002);
    wr(OFS_WIN2_BASE, 32'hffff_ffff);
    rd(OFS_WIN2_BASE, 32'hffff_0000);
    chk("win2 en", 32'h1, {31'h0, win2_enabled});
    wr(OFS_WIN2_BASE, 32'h2000_0000);
    wr(12'h104, 32'h7000_0001);
    wr(12'h100, 32'h5000_0000);
    rd(12'h104, 32'h7000_0001);
    rd(12'h100, 32'h5000_0000);
    xq(32'h2000_0412, 1'b0, 2'b01, 32'h7000_0012);
    xq(32'h2000_0012, 1'b0, 2'b00, 32'h2000_0012);
    xq(32'h2000_0412, 1'b1, 2'b00, 32'h2000_0412);
    xq(32'h2001_0000, 1'b0, 2'b00, 32'h2001_0000);
    wrap_up();
  end
endmodule : tb_top

// File: tb/uwb_regs_asserts.sv
`timescale 1ns/1ps
module uwb_regs_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [uwb_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [uwb_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire uwb_pkg::uwb_load_t load,
  input wire uwb_pkg::uwb_xreq_t xreq,
  input wire uwb_pkg::uwb_xrsp_t xrsp,
  input wire logic win1_enabled,
  input wire logic win2_enabled
);
  import uwb_pkg::*;
  logic [11:0] last_ar;
  logic [31:0] last_xa;
  logic last_io;

  // Answers are tied to the last request, which is exact only while
  // requests are not issued back to back.
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      last_ar <= s_axi_araddr;
    end
  end
  always_ff @(posedge aclk) begin
    if (xreq.valid) begin
      last_xa <= xreq.addr;
      last_io <= xreq.is_io;
    end
  end

  // ************************************************************
  // Properties
  // ************************************************************
  default clocking cb_chk @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_win1_off;
    load.valid && load.addr == OFS_WIN1_SETUP && !load.data[EN_BIT]
      |-> ##2 !win1_enabled;
  endproperty
  a_win1_off: assert property (p_win1_off)
    else $error("window 1 still enabled");
  property p_lat; xreq.valid |-> ##[2:3] xrsp.valid; endproperty
  a_lat: assert property (p_lat)
    else $error("translation result missing");
  property p_pass;
    xrsp.valid && !xrsp.hit1 && !xrsp.hit2 |-> xrsp.addr == last_xa;
  endproperty
  a_pass: assert property (p_pass)
    else $error("miss changed the address");
  property p_io; xrsp.valid && last_io |-> !xrsp.hit2; endproperty
  a_io: assert property (p_io)
    else $error("io request hit window 2");
  property p_hit1;
    xrsp.valid && xrsp.hit1 |-> win1_enabled || $past(win1_enabled);
  endproperty
  a_hit1: assert property (p_hit1)
    else $error("window 1 hit while disabled");
  property p_hit2;
    xrsp.valid && xrsp.hit2 |-> win2_enabled || $past(win2_enabled);
  endproperty
  a_hit2: assert property (p_hit2)
    else $error("window 2 hit while disabled");
  property p_w2ro;
    s_axi_rvalid && last_ar == OFS_WIN2_BASE
      |-> {s_axi_rdata[13:4], s_axi_rdata[2:0]} == 13'h0;
  endproperty
  a_w2ro: assert property (p_w2ro)
    else $error("window 2 fixed bits not zero");
  property p_w1ro;
    s_axi_rvalid && last_ar == OFS_WIN1_BASE |-> s_axi_rdata[5:4] == 2'h0;
  endproperty
  a_w1ro: assert property (p_w1ro)
    else $error("window 1 reserved bits not zero");
  c_hit1: cover property (xrsp.valid && xrsp.hit1);
  c_hit2: cover property (xrsp.valid && xrsp.hit2);
  c_decerr: cover property (s_axi_rvalid && s_axi_rresp == RESP_DECERR);
endmodule : uwb_regs_asserts

bind uwb_regs uwb_regs_asserts u_chk (.*);
